// [rtl/tgnc_consts.svh]
// sizes, field positions, register offsets and reset values of the task gate nesting block
`ifndef TGNC_CONSTS_SVH
`define TGNC_CONSTS_SVH
`define TGNC_OFF_CTRL 12'h000
`define TGNC_OFF_REQ 12'h004
`define TGNC_OFF_SEL 12'h008
`define TGNC_OFF_PRIV 12'h00C
`define TGNC_OFF_STAT 12'h010
`define TGNC_OFF_RES 12'h014
`define TGNC_OFF_LINK 12'h018
`define TGNC_OFF_BUSY 12'h01C
`define TGNC_BUSY_BIT 9
`define TGNC_BUSY_BYTE_OFF 4
`define TGNC_NUM_TASKS 16
`define TGNC_TASK_IDX_W 4
`define TGNC_REQ_GO_BIT 31
`define TGNC_RST_CTRL 32'h00000000
`endif

// [rtl/tgnc_pkg.sv]
// types shared by the task gate nesting block
`default_nettype none
package tgnc_pkg;
  typedef enum logic [1:0] {
    TGNC_KIND_JUMP = 2'h0,
    TGNC_KIND_CALL = 2'h1,
    TGNC_KIND_EVENT = 2'h2,
    TGNC_KIND_INTERRUPT_RETURN_INSTRUCTION = 2'h3
  } tgnc_kind_t;
  typedef enum logic [1:0] {
    TGNC_ST_IDLE = 2'h0,
    TGNC_ST_CHECK = 2'h1,
    TGNC_ST_COMMIT = 2'h3,
    TGNC_ST_DONE = 2'h2
  } tgnc_state_t;
  typedef enum logic [1:0] {
    TGNC_RES_OK = 2'h0,
    TGNC_RES_PRIV = 2'h1,
    TGNC_RES_BUSY = 2'h2,
    TGNC_RES_LONG = 2'h3
  } tgnc_res_t;
endpackage : tgnc_pkg
`default_nettype wire

// [rtl/tgnc_busy_if.sv]
// busy bit memory access bundle between the control core and its memory
`timescale 1ns/1ps
`default_nettype none
interface tgnc_busy_if;
  logic [3:0] rdIdx;
  logic rdBit;
  logic wrEn;
  logic [3:0] wrIdx;
  logic wrBit;
  logic [15:0] allBits;
  modport core (output rdIdx, output wrEn, output wrIdx, output wrBit, input rdBit, input allBits);
  modport mem (input rdIdx, input wrEn, input wrIdx, input wrBit, output rdBit, output allBits);
endinterface : tgnc_busy_if
`default_nettype wire

// [rtl/tgnc_busy_mem.sv]
// per-task busy bits of the task-state descriptors
`timescale 1ns/1ps
`default_nettype none
`include "tgnc_consts.svh"
module tgnc_busy_mem (
  input wire logic clock, // core clock
  input wire logic srst, // sync reset, high
  tgnc_busy_if.mem bus, // access port
  input wire logic swWrEn, // software overwrite of all bits
  input wire logic [15:0] swBits // software value
);
  logic [15:0] bits_ff;
  logic [15:0] nxt_bits;
  logic rd_ff;
  always_comb begin
    nxt_bits = bits_ff;
    if (swWrEn) begin
      nxt_bits = swBits;
    end
    if (bus.wrEn) begin
      nxt_bits[bus.wrIdx] = bus.wrBit;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      bits_ff <= 16'h0000;
      rd_ff <= 1'b0;
    end else begin
      bits_ff <= nxt_bits;
      rd_ff <= nxt_bits[bus.rdIdx];
    end
  end
  assign bus.rdBit = rd_ff;
  assign bus.allBits = bits_ff;
endmodule : tgnc_busy_mem
`default_nettype wire

// [rtl/tgnc_priv_cmp.sv]
// gate privilege comparison of two requester levels
`timescale 1ns/1ps
`default_nettype none
module tgnc_priv_cmp (
  input wire logic [1:0] currentPrivilegeLevel, // running level
  input wire logic [1:0] selectorRequestedPrivilege, // selector level
  input wire logic [1:0] gatePrivilegeLevel, // gate level
  output logic pass // both checks pass
);
  // unsigned compare, 0 most privileged
  wire cplOk = currentPrivilegeLevel <= gatePrivilegeLevel; // [R1] [R19]
  wire rplOk = selectorRequestedPrivilege <= gatePrivilegeLevel; // [R2] [R19]
  assign pass = cplOk & rplOk; // [R4]
endmodule : tgnc_priv_cmp
`default_nettype wire

// [rtl/task_gate_nesting_control.sv]
// apb-reached task switch permission and nesting bookkeeping core
//
// How it works
// R1: running level must not exceed gate level
// R2: selector level must not exceed gate level
// R3: target descriptor level never read with gates
// R4: either failing check denies the switch
// R5: gate use in long mode faults
// R6: jump keeps nested flag and link
// R7: call or event sets flag, stores link
// R8: return switches only if flag set, via link
// R9: return clears outgoing nested flag
// R10: busy bits per task forbid recursion
// R11: jump clears old busy, sets new
// R12: jump to busy task faults
// R13: call or event sets new busy, keeps old
// R14: call or event to busy task faults
// R15: return clears old busy, new untouched
// R16: any level may set flag and return
// R17: failed check alters nothing and faults
// R18: events skip the gate privilege check
// R19: levels are unsigned two-bit, 0 highest
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tgnc_consts.svh"
module task_gate_nesting_control (
  input wire logic clock, // core clock
  input wire logic srst, // sync reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic generalProtectionFault, // fault pulse
  output logic switchDone // accepted switch pulse
);
  logic [31:0] ctrl_ff;
  logic [31:0] req_ff;
  logic [15:0] sel_ff;
  logic [1:0] cpl_ff;
  logic [1:0] gpl_ff;
  logic [1:0] rpl_ff;
  logic [1:0] tdp_ff;
  logic nestedTaskFlag_ff;
  logic [15:0] curLink_ff;
  logic [15:0] newLink_ff;
  logic [3:0] curTask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic gpf_ff;
  logic done_ff;
  tgnc_pkg::tgnc_res_t res_ff;
  tgnc_pkg::tgnc_state_t state_ff;
  tgnc_pkg::tgnc_state_t nxt_state;
  logic [3:0] tgt_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] nxt_req;
  logic [15:0] nxt_sel;
  logic [7:0] nxt_priv;
  logic nxt_pready;
  logic nxt_pslverr;
  logic [31:0] nxt_prdata;
  tgnc_pkg::tgnc_res_t nxt_res;
  logic nxt_gpf;
  logic nxt_done;
  logic [3:0] nxt_tgt;
  logic nxt_nestedTaskFlag;
  logic [15:0] nxt_curLink;
  logic [15:0] nxt_newLink;
  logic [3:0] nxt_curTask;
  tgnc_busy_if busyBus ();
  // ctrl: bit0 long mode, bit1 through gate
  wire longMode = ctrl_ff[0];
  wire viaGate = ctrl_ff[1];
  wire [1:0] kindBits = req_ff[1:0];
  wire [3:0] reqTask = req_ff[11:8];
  wire isIret = kindBits == tgnc_pkg::TGNC_KIND_INTERRUPT_RETURN_INSTRUCTION;
  wire isJump = kindBits == tgnc_pkg::TGNC_KIND_JUMP;
  wire isEvent = kindBits == tgnc_pkg::TGNC_KIND_EVENT;
  // return targets the task named by the link selector
  wire [3:0] target = isIret ? curLink_ff[`TGNC_TASK_IDX_W-1:0] : reqTask; // [R8]
  wire privPass;
  // descriptor level never reaches the compare
  tgnc_priv_cmp u_cmp ( // [R3]
    .currentPrivilegeLevel(cpl_ff),
    .selectorRequestedPrivilege(rpl_ff),
    .gatePrivilegeLevel(gpl_ff),
    .pass(privPass)
  );
  wire gateChecked = viaGate & ~isEvent & ~isIret; // [R18]
  wire privFail = gateChecked & ~privPass; // [R4]
  wire longFail = longMode & viaGate; // [R5]
  wire busyFail = ~isIret & busyBus.rdBit; // [R12] [R14]
  wire iretNoNest = isIret & ~nestedTaskFlag_ff; // [R8]
  wire anyFail = longFail | privFail | busyFail;
  tgnc_pkg::tgnc_res_t nxtRes;
  assign nxtRes = longFail ? tgnc_pkg::TGNC_RES_LONG :
                  privFail ? tgnc_pkg::TGNC_RES_PRIV :
                  busyFail ? tgnc_pkg::TGNC_RES_BUSY : tgnc_pkg::TGNC_RES_OK;
  // apb decode
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hitCtrl = paddr == `TGNC_OFF_CTRL;
  wire hitReq = paddr == `TGNC_OFF_REQ;
  wire hitSel = paddr == `TGNC_OFF_SEL;
  wire hitPriv = paddr == `TGNC_OFF_PRIV;
  wire hitStat = paddr == `TGNC_OFF_STAT;
  wire hitRes = paddr == `TGNC_OFF_RES;
  wire hitLink = paddr == `TGNC_OFF_LINK;
  wire hitBusy = paddr == `TGNC_OFF_BUSY;
  wire mapped = hitCtrl | hitReq | hitSel | hitPriv | hitStat | hitRes | hitLink | hitBusy;
  wire idle = state_ff == tgnc_pkg::TGNC_ST_IDLE;
  wire goWr = wr & hitReq & pwdata[`TGNC_REQ_GO_BIT] & idle;
  // software may set the flag at any level before a return
  wire flagWr = wr & hitStat & idle; // [R16]
  wire [31:0] rdMux = hitCtrl ? ctrl_ff :
                      hitReq ? {~idle, req_ff[30:0]} :
                      hitSel ? {16'h0000, sel_ff} :
                      hitPriv ? {24'h000000, tdp_ff, rpl_ff, gpl_ff, cpl_ff} :
                      hitStat ? {11'h000, curTask_ff, nestedTaskFlag_ff, curLink_ff} :
                      hitRes ? {26'h0000000, done_ff, gpf_ff, 2'h0, res_ff} :
                      hitLink ? {16'h0000, newLink_ff} :
                      hitBusy ? {16'h0000, busyBus.allBits} : 32'h00000000;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tgnc_pkg::TGNC_ST_IDLE: if (goWr) nxt_state = tgnc_pkg::TGNC_ST_CHECK;
      tgnc_pkg::TGNC_ST_CHECK: nxt_state = tgnc_pkg::TGNC_ST_COMMIT;
      tgnc_pkg::TGNC_ST_COMMIT: nxt_state = tgnc_pkg::TGNC_ST_DONE;
      tgnc_pkg::TGNC_ST_DONE: nxt_state = tgnc_pkg::TGNC_ST_IDLE;
      default: nxt_state = tgnc_pkg::TGNC_ST_IDLE;
    endcase
  end
  wire inCommit = state_ff == tgnc_pkg::TGNC_ST_COMMIT;
  // faults leave all task state untouched
  wire commitOk = inCommit & ~anyFail & ~iretNoNest; // [R17]
  wire commitFault = inCommit & anyFail; // [R17]
  // check cycle reads target busy, commit writes old task's busy
  assign busyBus.rdIdx = target;
  wire oldClr = commitOk & (isJump | isIret); // [R11] [R15]
  // new task's busy bit is set the cycle after commit, from tgt_ff
  wire newSet = (state_ff == tgnc_pkg::TGNC_ST_DONE) & done_ff & ~isIret; // [R11] [R13]
  assign busyBus.wrEn = oldClr | newSet; // [R10]
  assign busyBus.wrIdx = newSet ? tgt_ff : curTask_ff;
  assign busyBus.wrBit = newSet; // [R13]
  tgnc_busy_mem u_mem (
    .clock(clock),
    .srst(srst),
    .bus(busyBus),
    .swWrEn(wr & hitBusy & idle),
    .swBits(pwdata[15:0])
  );
  // apb answer: ready one cycle after setup, read data caught at setup
  assign nxt_pready = setup;
  assign nxt_pslverr = setup & ~mapped;
  assign nxt_prdata = (setup & ~pwrite) ? rdMux : prdata_ff;
  // control stays writable mid-switch; the rest waits for idle
  assign nxt_ctrl = (wr & hitCtrl) ? pwdata : ctrl_ff;
  assign nxt_req = goWr ? {1'b0, pwdata[30:0]} : req_ff;
  assign nxt_sel = (wr & hitSel & idle) ? pwdata[15:0] : sel_ff;
  assign nxt_priv = (wr & hitPriv & idle) ? pwdata[7:0] : {tdp_ff, rpl_ff, gpl_ff, cpl_ff};
  always_ff @(posedge clock) begin
    if (srst) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      pslverr_ff <= 1'b0;
    end else begin
      pslverr_ff <= nxt_pslverr;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata_ff <= 32'h00000000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_ff <= `TGNC_RST_CTRL;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      req_ff <= 32'h00000000;
    end else begin
      req_ff <= nxt_req;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      sel_ff <= 16'h0000;
    end else begin
      sel_ff <= nxt_sel;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      {tdp_ff, rpl_ff, gpl_ff, cpl_ff} <= 8'h00;
    end else begin
      {tdp_ff, rpl_ff, gpl_ff, cpl_ff} <= nxt_priv;
    end
  end
  // outcome pulses are exclusive and last one cycle
  assign nxt_res = inCommit ? nxtRes : res_ff;
  assign nxt_gpf = commitFault; // [R17]
  assign nxt_done = commitOk;
  // target kept so the busy write of the next cycle still knows it
  assign nxt_tgt = commitOk ? target : tgt_ff;
  always_ff @(posedge clock) begin
    if (srst) begin
      state_ff <= tgnc_pkg::TGNC_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      res_ff <= tgnc_pkg::TGNC_RES_OK;
    end else begin
      res_ff <= nxt_res;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      gpf_ff <= 1'b0;
    end else begin
      gpf_ff <= nxt_gpf;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      tgt_ff <= 4'h0;
    end else begin
      tgt_ff <= nxt_tgt;
    end
  end
  // nesting state: only a committed switch or an idle write moves it
  wire nestSet = commitOk & ~isIret & ~isJump; // [R7]
  wire nestClr = commitOk & isIret; // [R9]
  // a jump falls through every flag and link term below and keeps flag and link [R6]
  assign nxt_nestedTaskFlag = nestSet ? 1'b1 :
                              nestClr ? 1'b0 :
                              flagWr ? pwdata[16] : nestedTaskFlag_ff; // [R16]
  assign nxt_curLink = nestSet ? {12'h000, curTask_ff} : // [R7]
                       flagWr ? pwdata[15:0] : curLink_ff;
  assign nxt_newLink = nestSet ? sel_ff : newLink_ff;
  assign nxt_curTask = commitOk ? target :
                       flagWr ? pwdata[20:17] : curTask_ff;
  always_ff @(posedge clock) begin
    if (srst) begin
      nestedTaskFlag_ff <= 1'b0;
    end else begin
      nestedTaskFlag_ff <= nxt_nestedTaskFlag;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      curLink_ff <= 16'h0000;
    end else begin
      curLink_ff <= nxt_curLink;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      newLink_ff <= 16'h0000;
    end else begin
      newLink_ff <= nxt_newLink;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      curTask_ff <= 4'h0;
    end else begin
      curTask_ff <= nxt_curTask;
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign generalProtectionFault = gpf_ff;
  assign switchDone = done_ff;
endmodule : task_gate_nesting_control
`default_nettype wire

// [verif/tgnc_chk_sva.sv]
// port assertions of the task gate nesting block
`timescale 1ns/1ps
`default_nettype none
module tgnc_chk (
  input wire logic clock, // clk
  input wire logic srst, // reset
  input wire logic psel, // sel
  input wire logic penable, // enable
  input wire logic pwrite, // dir
  input wire logic [11:0] paddr, // addr
  input wire logic [31:0] pwdata, // wdata
  input wire logic [31:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic generalProtectionFault, // refusal
  input wire logic switchDone // commit
);
  logic longGate_ff;
  wire wrAcc = psel && penable && pwrite && pready;
  wire req = wrAcc && paddr == 12'h004 && pwdata[31];
  // outside long mode through a gate, a return with the nested flag clear gives neither pulse, so returns stay out of go
  wire go = req && pwdata[1:0] != 2'h3;
  always_ff @(posedge clock) begin
    if (srst) longGate_ff <= 1'h0;
    else if (wrAcc && paddr == 12'h000) longGate_ff <= &pwdata[1:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  apb_ready_a: assert property (psel && !penable |=> pready) else $error("no ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad read");
  one_outcome_a: assert property (go |-> ##3 (generalProtectionFault ^ switchDone))
    else $error("no single outcome");
  long_fault_a: assert property (go && longGate_ff |-> ##3 generalProtectionFault)
    else $error("long mode gate not refused");
  gpf_pulse_a: assert property (generalProtectionFault |=> !generalProtectionFault)
    else $error("fault too long");
  done_pulse_a: assert property (switchDone |=> !switchDone) else $error("done too long");
  pulse_cause_a: assert property (generalProtectionFault || switchDone |-> $past(req, 3))
    else $error("pulse without request");
  rst_quiet_a: assert property (disable iff (1'h0)
    srst |=> !(pready || switchDone || generalProtectionFault)) else $error("reset not quiet");
endmodule : tgnc_chk
bind task_gate_nesting_control tgnc_chk u_chk (.clock(clock), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .generalProtectionFault(generalProtectionFault),
  .switchDone(switchDone));
`default_nettype wire

// [verif/task_gate_nesting_control_test.sv]
// random and directed bench of the task gate nesting block
`timescale 1ns/1ps
`default_nettype none
`include "tgnc_consts.svh"
module task_gate_nesting_control_test;
  logic clock = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h0001079D;
  logic pready, pslverr, gpf, done, err;
  int n_errors = 0, samples_checked = 0, nG = 0, nD = 0, ok;
  task_gate_nesting_control u_dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .generalProtectionFault(gpf), .switchDone(done));
  always #2.5 clock = ~clock;
  // pulses last one cycle, so count them at every edge
  always @(posedge clock) begin
    if (gpf === 1'h1) nG++;
    if (done === 1'h1) nD++;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic int privOk(input logic [1:0] c, input logic [1:0] r, input logic [1:0] g);
    return int'(c <= g && r <= g);
  endfunction : privOk
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : apb
  task automatic setup(input logic [31:0] c, input logic [31:0] b, input logic [31:0] s,
    input logic [31:0] p);
    apb(1'h1, `TGNC_OFF_CTRL, c);
    apb(1'h1, `TGNC_OFF_BUSY, b);
    apb(1'h1, `TGNC_OFF_STAT, s);
    apb(1'h1, `TGNC_OFF_PRIV, p);
  endtask : setup
  task automatic sw(input tgnc_pkg::tgnc_kind_t kind, input logic [3:0] t, input int eG,
    input int eD, input logic [31:0] eBusy);
    int g;
    int d;
    g = nG;
    d = nD;
    apb(1'h1, `TGNC_OFF_REQ, {1'h1, 19'h0, t, 6'h0, kind});
    repeat (4) @(posedge clock);
    check(32'(nG - g), 32'(eG));
    check(32'(nD - d), 32'(eD));
    apb(1'h0, `TGNC_OFF_BUSY, 32'h0);
    check(rd, eBusy);
  endtask : sw
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'h0;
    @(posedge clock);
    apb(1'h0, `TGNC_OFF_CTRL, 32'h0);
    check(rd, `TGNC_RST_CTRL);
    apb(1'h0, 12'h020, 32'h0);
    check({31'h0, err}, 32'h1);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      ok = privOk(seed[1:0], seed[5:4], seed[3:2]) | int'(seed[8]);
      setup(32'h2, 32'h1, 32'h0, {24'h0, seed[7:0]});
      sw(seed[8] ? tgnc_pkg::TGNC_KIND_EVENT : tgnc_pkg::TGNC_KIND_CALL, {seed[11:9], 1'h1},
        1 - ok, ok, ok ? 32'h1 | (32'h1 << {seed[11:9], 1'h1}) : 32'h1);
      apb(1'h0, `TGNC_OFF_RES, 32'h0);
      check(32'(rd[1:0]), ok ? 32'h0 : 32'h1);
    end
    setup(32'h2, 32'h1, 32'h0, 32'h0);
    sw(tgnc_pkg::TGNC_KIND_CALL, 4'h5, 0, 1, 32'h21);
    apb(1'h0, `TGNC_OFF_STAT, 32'h0);
    check(rd, 32'h000B0000);
    sw(tgnc_pkg::TGNC_KIND_CALL, 4'h0, 1, 0, 32'h21);
    apb(1'h0, `TGNC_OFF_STAT, 32'h0);
    check(rd, 32'h000B0000);
    sw(tgnc_pkg::TGNC_KIND_JUMP, 4'h3, 0, 1, 32'h9);
    apb(1'h0, `TGNC_OFF_STAT, 32'h0);
    check(rd, 32'h00070000);
    sw(tgnc_pkg::TGNC_KIND_JUMP, 4'h0, 1, 0, 32'h9);
    setup(32'h0, 32'h84, 32'h00050007, 32'h3);
    sw(tgnc_pkg::TGNC_KIND_INTERRUPT_RETURN_INSTRUCTION, 4'h0, 0, 1, 32'h80);
    apb(1'h0, `TGNC_OFF_STAT, 32'h0);
    check(32'(rd[20:16]), 32'hE);
    sw(tgnc_pkg::TGNC_KIND_INTERRUPT_RETURN_INSTRUCTION, 4'h0, 0, 0, 32'h80);
    setup(32'h3, 32'h1, 32'h0, 32'h0);
    sw(tgnc_pkg::TGNC_KIND_CALL, 4'h5, 1, 0, 32'h1);
    apb(1'h0, `TGNC_OFF_RES, 32'h0);
    check(32'(rd[1:0]), 32'h3);
    summarize();
  end
  initial begin
    #20000;
    n_errors++;
    summarize();
  end
endmodule : task_gate_nesting_control_test
`default_nettype wire
